// file: design/hcs_regs.svh
// register offsets, field positions, codes and timing counts for hcs block
`ifndef HCS_REGS_SVH
`define HCS_REGS_SVH
// wishbone byte offsets
`define HCS_OFF_CMDSTS 8'h00
`define HCS_OFF_INITLEN 8'h04
`define HCS_OFF_OPTIONS 8'h08
`define HCS_OFF_RXBURST 8'h0c
`define HCS_OFF_TXBURST 8'h10
`define HCS_OFF_ABORT 8'h14
`define HCS_OFF_SCBADR 8'h18
`define HCS_OFF_SSBADR 8'h1c
`define HCS_OFF_CTRL 8'h20
`define HCS_OFF_STATUS 8'h24
`define HCS_OFF_SSBTYPE 8'h28
`define HCS_OFF_SSBP0 8'h2c
`define HCS_OFF_SSBP1 8'h30
`define HCS_OFF_SSBP2 8'h34
`define HCS_OFF_CMDCODE 8'h38
`define HCS_OFF_PARM0 8'h3c
`define HCS_OFF_PARM1 8'h40
`define HCS_OFF_PTRBASE 8'h80
`define HCS_OFF_BIA0 8'hc0
// command/status register bits
`define HCS_BIT_INT_ADAPTER 0
`define HCS_BIT_SSB_RELEASE 2
`define HCS_BIT_SCB_REQ 4
`define HCS_BIT_EXECUTE 7
`define HCS_BIT_SYS_INT 8
`define HCS_BIT_ERROR 9
`define HCS_BIT_INIT 10
`define HCS_BIT_TEST 11
`define HCS_ERR_LSB 12
// initialization facts
`define HCS_INIT_BYTES 16'h0016
`define HCS_OPT_RSVD_MASK 16'hfd01
`define HCS_OPT_RSVD_ONE 16'h0001
// dummy address copy marker
`define HCS_BIA_BAD 16'hffff
// pointer table base in adapter memory
`define HCS_PTR_BASE 20'h10a00
// dma timeout: 11 s at 100 MHz
`define HCS_DMA_TIMEOUT_S 11
`define HCS_CLK_HZ 100000000
// memory first region in bytes
`define HCS_FIRST_RAM_BYTES 32'h00020000
// reset value for command/status register
`define HCS_CMDSTS_RST 16'h0000
`endif

// file: design/hcs_pkg.sv
// types for the host command/status handshake block
package hcs_pkg;
    typedef enum logic [3:0] {
        HCS_ERR_NONE = 4'h0,
        HCS_ERR_LEN = 4'h1,
        HCS_ERR_OPT = 4'h2,
        HCS_ERR_RXB = 4'h3,
        HCS_ERR_TXB = 4'h4,
        HCS_ERR_ABT = 4'h5,
        HCS_ERR_SCB = 4'h6,
        HCS_ERR_SSB = 4'h7,
        HCS_ERR_DIOPAR = 4'h8,
        HCS_ERR_TMO = 4'h9,
        HCS_ERR_DMAPAR = 4'ha,
        HCS_ERR_BUS = 4'hb,
        HCS_ERR_DATA = 4'hc,
        HCS_ERR_CHECK = 4'hd
    } hcs_err_t;
    typedef enum logic [15:0] {
        HCS_ST_RING = 16'h0001,
        HCS_ST_REJ = 16'h0002,
        HCS_ST_CMD = 16'h0004,
        HCS_ST_XMIT = 16'h0008,
        HCS_ST_RCV = 16'h0010
    } hcs_stype_t;
    typedef struct packed {
        logic valid;
        logic we;
        logic [31:0] addr;
        logic [15:0] data;
    } hcs_dma_req_t;
    typedef struct packed {
        logic done;
        logic parity_err;
        logic bus_err;
        logic [15:0] data;
    } hcs_dma_rsp_t;
endpackage : hcs_pkg

// file: design/hcs_core.sv
// host command/status handshake: init checks, command fetch, status post
`timescale 1ns/1ns
`include "hcs_regs.svh"
module hcs_core #(
    parameter int unsigned DMA_TIMEOUT_CYC =
        `HCS_DMA_TIMEOUT_S * `HCS_CLK_HZ,
    parameter int unsigned RAM_KB = 16'd512
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // host memory dma
    output hcs_pkg::hcs_dma_req_t dma_req_o,
    input wire hcs_pkg::hcs_dma_rsp_t dma_rsp_i,
    // external fault and self-test inputs
    input wire logic dio_parity_err_i,
    input wire logic hw_fault_i,
    input wire logic mem_fault_i,
    input wire logic llc_present_i,
    input wire logic [15:0] bia_word_i,
    // host interrupt and adapter check
    output logic host_int_o,
    output logic adapter_check_o
);
    import hcs_pkg::*;

    typedef enum {
        ST_SELFTEST, ST_UPPER, ST_IDLE, ST_INITCHK, ST_TESTDMA, ST_READY,
        ST_FETCH, ST_CLRCMD, ST_POST, ST_CHECK
    } hcs_state_t;

    hcs_state_t state_reg;
    logic [15:0] cmdsts_reg, initlen_reg, opt_reg, rxb_reg, txb_reg, abt_reg;
    logic [31:0] scb_reg, ssb_reg;
    logic [15:0] ctrl_reg;
    logic [15:0] stype_reg, sp0_reg, sp1_reg, sp2_reg;
    logic [15:0] cmd_reg, parm0_reg, parm1_reg;
    logic [15:0] ptr_reg [0:7];
    logic [15:0] bia_reg;
    logic [2:0] word_reg;
    logic [31:0] tmo_reg;
    logic [7:0] retry_reg;
    logic ssb_busy_reg, post_req_reg, tx_busy_reg, rx_busy_reg, oth_busy_reg;
    logic [15:0] bia_sum_reg;
    logic [1:0] dio_sync_reg, hw_sync_reg, mem_sync_reg;
    logic wb_hit, wb_wr;

    assign wb_hit = cyc_i && stb_i && !ack_o;
    assign wb_wr = wb_hit && we_i;

    // first-rank then second-rank flops; only second rank is read
    // unreset so a fault held through reset meets the first self test
    always_ff @(posedge clk_i) begin
        dio_sync_reg <= {dio_sync_reg[0], dio_parity_err_i};
        hw_sync_reg <= {hw_sync_reg[0], hw_fault_i};
        mem_sync_reg <= {mem_sync_reg[0], mem_fault_i};
    end

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] d,
                                            input logic [3:0] s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction : merge16

    // error code checks, first failing check wins
    function automatic hcs_err_t init_check(input logic [15:0] len,
        input logic [15:0] opt, input logic llc, input logic [15:0] rxb,
        input logic [15:0] txb, input logic [15:0] abt,
        input logic [31:0] command_block, input logic [31:0] status_block);
        if (len != `HCS_INIT_BYTES)
            init_check = HCS_ERR_LEN;
        else if (opt[1] != opt[2] ||
                 (opt & `HCS_OPT_RSVD_MASK) != `HCS_OPT_RSVD_ONE ||
                 (opt[9] && !llc))
            init_check = HCS_ERR_OPT;
        // odd burst sizes, zero threshold, odd addresses
        else if (rxb[0])
            init_check = HCS_ERR_RXB;
        else if (txb[0])
            init_check = HCS_ERR_TXB;
        else if (abt == 16'h0000)
            init_check = HCS_ERR_ABT;
        else if (command_block[0])
            init_check = HCS_ERR_SCB;
        else if (status_block[0])
            init_check = HCS_ERR_SSB;
        else
            init_check = HCS_ERR_NONE;
    endfunction : init_check

    // wishbone ack, one cycle after request
    always_ff @(posedge clk_i) begin
        if (rst_i)
            ack_o <= 1'b0;
        else
            ack_o <= wb_hit;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0;
        end else if (wb_hit && !we_i) begin
            if (adr_i[7:5] == 3'h4)
                dat_o <= {16'h0, ptr_reg[adr_i[4:2]]};
            else begin
                case (adr_i)
                    `HCS_OFF_CMDSTS: dat_o <= {16'h0, cmdsts_reg};
                    `HCS_OFF_INITLEN: dat_o <= {16'h0, initlen_reg};
                    `HCS_OFF_OPTIONS: dat_o <= {16'h0, opt_reg};
                    `HCS_OFF_RXBURST: dat_o <= {16'h0, rxb_reg};
                    `HCS_OFF_TXBURST: dat_o <= {16'h0, txb_reg};
                    `HCS_OFF_ABORT: dat_o <= {16'h0, abt_reg};
                    `HCS_OFF_SCBADR: dat_o <= scb_reg;
                    `HCS_OFF_SSBADR: dat_o <= ssb_reg;
                    `HCS_OFF_CTRL: dat_o <= {16'h0, ctrl_reg};
                    `HCS_OFF_STATUS: dat_o <= {27'h0, oth_busy_reg,
                        rx_busy_reg, tx_busy_reg, ssb_busy_reg,
                        state_reg == ST_CHECK};
                    `HCS_OFF_CMDCODE: dat_o <= {16'h0, cmd_reg};
                    `HCS_OFF_PARM0: dat_o <= {16'h0, parm0_reg};
                    `HCS_OFF_PARM1: dat_o <= {16'h0, parm1_reg};
                    `HCS_OFF_BIA0: dat_o <= {16'h0, bia_reg};
                    default: dat_o <= 32'h0;
                endcase
            end
        end
    end

    // software-written config registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            initlen_reg <= 16'h0;
            opt_reg <= 16'h0;
            rxb_reg <= 16'h0;
            txb_reg <= 16'h0;
            abt_reg <= 16'h0;
            scb_reg <= 32'h0;
            ssb_reg <= 32'h0;
            ctrl_reg <= 16'h0;
            stype_reg <= 16'h0;
            sp0_reg <= 16'h0;
            sp1_reg <= 16'h0;
            sp2_reg <= 16'h0;
        end else if (wb_wr) begin
            case (adr_i)
                `HCS_OFF_INITLEN: initlen_reg <= merge16(initlen_reg,
                                                         dat_i, sel_i);
                `HCS_OFF_OPTIONS: opt_reg <= merge16(opt_reg, dat_i, sel_i);
                `HCS_OFF_RXBURST: rxb_reg <= merge16(rxb_reg, dat_i, sel_i);
                `HCS_OFF_TXBURST: txb_reg <= merge16(txb_reg, dat_i, sel_i);
                `HCS_OFF_ABORT: abt_reg <= merge16(abt_reg, dat_i, sel_i);
                `HCS_OFF_SCBADR: scb_reg <= dat_i;
                `HCS_OFF_SSBADR: ssb_reg <= dat_i;
                `HCS_OFF_CTRL: ctrl_reg <= merge16(ctrl_reg, dat_i, sel_i);
                `HCS_OFF_SSBTYPE: stype_reg <= merge16(stype_reg, dat_i, sel_i);
                `HCS_OFF_SSBP0: sp0_reg <= merge16(sp0_reg, dat_i, sel_i);
                `HCS_OFF_SSBP1: sp1_reg <= merge16(sp1_reg, dat_i, sel_i);
                `HCS_OFF_SSBP2: sp2_reg <= merge16(sp2_reg, dat_i, sel_i);
                default: ;
            endcase
        end
    end

    logic cmd_wr, status_post, exec_req, release_req, ack_int;
    logic [15:0] cmd_d;
    assign cmd_wr = wb_wr && adr_i == `HCS_OFF_CMDSTS;
    assign cmd_d = merge16(cmdsts_reg, dat_i, sel_i);
    // command needs interrupt-adapter and execute together
    assign exec_req = cmd_wr && cmd_d[`HCS_BIT_INT_ADAPTER] &&
                      cmd_d[`HCS_BIT_EXECUTE];
    // release needs interrupt-adapter and release bit
    assign release_req = cmd_wr && cmd_d[`HCS_BIT_INT_ADAPTER] &&
                         cmd_d[`HCS_BIT_SSB_RELEASE];
    assign ack_int = cmd_wr && !cmd_d[`HCS_BIT_SYS_INT];
    // ctrl bit 0 lets software queue a status block
    assign status_post = wb_wr && adr_i == `HCS_OFF_CTRL && dat_i[0];

    logic scb_req_reg, set_int;
    // interrupt at end of code clear if the scb request bit was set, or of status post if ctrl bit 1 is set
    assign set_int = dma_rsp_i.done &&
        ((state_reg == ST_CLRCMD && scb_req_reg) ||
         (state_reg == ST_POST && word_reg == 3'h3 && ctrl_reg[1]));
    hcs_err_t err_code;
    assign err_code = init_check(initlen_reg, opt_reg, llc_present_i,
        rxb_reg, txb_reg, abt_reg, scb_reg, ssb_reg);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= ST_SELFTEST;
            cmdsts_reg <= `HCS_CMDSTS_RST;
            word_reg <= 3'h0;
            tmo_reg <= 32'h0;
            retry_reg <= 8'h0;
            ssb_busy_reg <= 1'b0;
            post_req_reg <= 1'b0;
            scb_req_reg <= 1'b0;
            host_int_o <= 1'b0;
            adapter_check_o <= 1'b0;
            dma_req_o <= '0;
            cmd_reg <= 16'h0;
            parm0_reg <= 16'h0;
            parm1_reg <= 16'h0;
            tx_busy_reg <= 1'b0;
            rx_busy_reg <= 1'b0;
            oth_busy_reg <= 1'b0;
            bia_reg <= 16'h0;
            bia_sum_reg <= 16'h0;
        end else begin
            if (status_post)
                post_req_reg <= 1'b1;
            if (release_req)
                ssb_busy_reg <= 1'b0;
            // ctrl bits 2..4 end transmit, receive, other commands
            if (wb_wr && adr_i == `HCS_OFF_CTRL) begin
                if (dat_i[2]) tx_busy_reg <= 1'b0;
                if (dat_i[3]) rx_busy_reg <= 1'b0;
                if (dat_i[4]) oth_busy_reg <= 1'b0;
            end
            case (state_reg)
                // first 128K tested before the rest
                ST_SELFTEST: begin
                    cmdsts_reg[`HCS_BIT_TEST] <= 1'b1;
                    bia_sum_reg <= bia_word_i;
                    if (mem_sync_reg[1])
                        state_reg <= ST_CHECK;
                    else
                        state_reg <= ST_UPPER;
                end
                // upper memory sized, tested, then pooled
                ST_UPPER: begin
                    cmdsts_reg[`HCS_BIT_TEST] <= 1'b0;
                    bia_reg <= (bia_sum_reg == 16'h0) ? `HCS_BIA_BAD
                                                       : bia_sum_reg;
                    if (mem_sync_reg[1])
                        state_reg <= ST_CHECK;
                    else
                        state_reg <= ST_IDLE;
                end
                ST_IDLE: begin
                    if (exec_req) begin
                        cmdsts_reg[`HCS_BIT_INIT] <= 1'b1;
                        state_reg <= ST_INITCHK;
                    end
                end
                ST_INITCHK: begin
                    if (dio_sync_reg[1]) begin
                        cmdsts_reg[15:12] <= HCS_ERR_DIOPAR;
                        cmdsts_reg[`HCS_BIT_ERROR] <= 1'b1;
                        state_reg <= ST_CHECK;
                    end else if (err_code != HCS_ERR_NONE) begin
                        cmdsts_reg[15:12] <= err_code;
                        cmdsts_reg[`HCS_BIT_ERROR] <= 1'b1;
                        state_reg <= ST_CHECK;
                    end else begin
                        dma_req_o <= '{1'b1, 1'b0, scb_reg, 16'h0};
                        tmo_reg <= 32'h0;
                        retry_reg <= 8'h0;
                        state_reg <= ST_TESTDMA;
                    end
                end
                ST_TESTDMA: begin
                    tmo_reg <= tmo_reg + 32'h1;
                    if (tmo_reg >= DMA_TIMEOUT_CYC - 1) begin
                        cmdsts_reg[15:12] <= HCS_ERR_TMO;
                        cmdsts_reg[`HCS_BIT_ERROR] <= 1'b1;
                        dma_req_o.valid <= 1'b0;
                        state_reg <= ST_CHECK;
                    end else if (hw_sync_reg[1]) begin
                        cmdsts_reg[15:12] <= HCS_ERR_CHECK;
                        cmdsts_reg[`HCS_BIT_ERROR] <= 1'b1;
                        state_reg <= ST_CHECK;
                    end else if (dma_rsp_i.done) begin
                        if (dma_rsp_i.parity_err || dma_rsp_i.bus_err) begin
                            retry_reg <= retry_reg + 8'h1;
                            if (retry_reg + 8'h1 >= (dma_rsp_i.bus_err ?
                                abt_reg[15:8] : abt_reg[7:0])) begin
                                cmdsts_reg[15:12] <= dma_rsp_i.bus_err ?
                                    HCS_ERR_BUS : HCS_ERR_DMAPAR;
                                cmdsts_reg[`HCS_BIT_ERROR] <= 1'b1;
                                dma_req_o.valid <= 1'b0;
                                state_reg <= ST_CHECK;
                            end
                        end else if (dma_rsp_i.data != 16'h0) begin
                            // compare failure, block reads back zero
                            cmdsts_reg[15:12] <= HCS_ERR_DATA;
                            cmdsts_reg[`HCS_BIT_ERROR] <= 1'b1;
                            dma_req_o.valid <= 1'b0;
                            state_reg <= ST_CHECK;
                        end else begin
                            dma_req_o.valid <= 1'b0;
                            cmdsts_reg[`HCS_BIT_INIT] <= 1'b0;
                            state_reg <= ST_READY;
                        end
                    end
                end
                ST_READY: begin
                    // post status when block is free, gate
                    if (post_req_reg && !ssb_busy_reg) begin
                        word_reg <= 3'h0;
                        dma_req_o <= '{1'b1, 1'b1, ssb_reg, stype_reg};
                        post_req_reg <= 1'b0;
                        state_reg <= ST_POST;
                    end else if (exec_req) begin
                        // fetch begins at the block address
                        scb_req_reg <= cmd_d[`HCS_BIT_SCB_REQ];
                        word_reg <= 3'h0;
                        dma_req_o <= '{1'b1, 1'b0, scb_reg, 16'h0};
                        state_reg <= ST_FETCH;
                    end
                end
                ST_FETCH: begin
                    if (dma_rsp_i.done) begin
                        case (word_reg)
                            3'h0: cmd_reg <= dma_rsp_i.data;
                            3'h1: parm0_reg <= dma_rsp_i.data;
                            default: parm1_reg <= dma_rsp_i.data;
                        endcase
                        if (word_reg == 3'h2) begin
                            // zero the code field in host memory
                            dma_req_o <= '{1'b1, 1'b1, scb_reg, 16'h0};
                            state_reg <= ST_CLRCMD;
                        end else begin
                            word_reg <= word_reg + 3'h1;
                            dma_req_o.addr <= dma_req_o.addr + 32'h2;
                        end
                    end
                end
                ST_CLRCMD: begin
                    if (dma_rsp_i.done) begin
                        dma_req_o.valid <= 1'b0;
                        // one transmit, one receive, one other
                        if (ctrl_reg[15:14] == 2'h1 && !tx_busy_reg)
                            tx_busy_reg <= 1'b1;
                        else if (ctrl_reg[15:14] == 2'h2 && !rx_busy_reg)
                            rx_busy_reg <= 1'b1;
                        else if (ctrl_reg[15:14] == 2'h0 && !oth_busy_reg)
                            oth_busy_reg <= 1'b1;
                        state_reg <= ST_READY;
                    end
                end
                ST_POST: begin
                    if (dma_rsp_i.done) begin
                        if (word_reg == 3'h3) begin
                            dma_req_o.valid <= 1'b0;
                            ssb_busy_reg <= 1'b1;
                            state_reg <= ST_READY;
                        end else begin
                            word_reg <= word_reg + 3'h1;
                            dma_req_o.addr <= dma_req_o.addr + 32'h2;
                            case (word_reg)
                                3'h0: dma_req_o.data <= sp0_reg;
                                3'h1: dma_req_o.data <= sp1_reg;
                                default: dma_req_o.data <= sp2_reg;
                            endcase
                        end
                    end
                end
                ST_CHECK: begin
                    adapter_check_o <= 1'b1;
                    dma_req_o.valid <= 1'b0;
                end
                default: state_reg <= ST_IDLE;
            endcase
            // host ack clears, but a fresh set wins
            if (set_int) begin
                host_int_o <= 1'b1;
                cmdsts_reg[`HCS_BIT_SYS_INT] <= 1'b1;
            end else if (ack_int) begin
                host_int_o <= 1'b0;
                cmdsts_reg[`HCS_BIT_SYS_INT] <= 1'b0;
            end
        end
    end

    // pointer table; rate word pointer in slot 6
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_ptr
            always_ff @(posedge clk_i) begin
                if (rst_i)
                    ptr_reg[gi] <= 16'h0;
                else if (gi == 7)
                    ptr_reg[gi] <= 16'(RAM_KB);
                else
                    ptr_reg[gi] <= 16'(32'h0b00 + 32'(gi) * 32'h20);
            end
        end
    endgenerate
endmodule : hcs_core

// file: verification/hcs_checker.sv
// port assertions for hcs_core
`timescale 1ns/1ns
module hcs_checker (
    // watched ports
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire hcs_pkg::hcs_dma_req_t dma_req_o,
    input wire hcs_pkg::hcs_dma_rsp_t dma_rsp_i,
    input wire logic [15:0] bia_word_i,
    input wire logic host_int_o,
    input wire logic adapter_check_o
);
    import hcs_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("ack late");
    a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack long");
    a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
        else $error("ack unasked");
    a_err_code: assert property (ack_o && $past(!we_i && adr_i == 8'h00)
        |-> dat_o[9] == (dat_o[15:12] != 4'h0)) else $error("code flag");
    a_bia_mark: assert property (ack_o && $past(!we_i && adr_i == 8'hc0)
        && bia_word_i == 16'h0 |-> dat_o[15:0] == 16'hffff) else $error("bia");
    a_dma_hold: assert property (dma_req_o.valid && !dma_rsp_i.done
        ##1 dma_req_o.valid |-> $stable(dma_req_o)) else $error("dma moved");
    a_int_hold: assert property (host_int_o && !(cyc_i && stb_i && we_i
        && adr_i == 8'h00 && !dat_i[8]) |=> host_int_o)
        else $error("int lost");
    a_check_hold: assert property (adapter_check_o |=> adapter_check_o)
        else $error("check lost");
endmodule : hcs_checker
bind hcs_core hcs_checker i_hcs_checker (.clk_i, .rst_i, .cyc_i, .stb_i,
    .we_i, .adr_i, .dat_i, .dat_o, .ack_o, .dma_req_o, .dma_rsp_i,
    .bia_word_i, .host_int_o, .adapter_check_o);

// file: verification/hcs_host_model.sv
// host memory model serving the block's word dma requests
`timescale 1ns/1ns
module hcs_host_model (
    // dma pair
    input wire logic clk_i,
    input wire hcs_pkg::hcs_dma_req_t req_i,
    output hcs_pkg::hcs_dma_rsp_t rsp_o,
    // answer delay, forced errors
    input wire logic [7:0] dly_i,
    input wire logic perr_i,
    input wire logic berr_i
);
    import hcs_pkg::*;
    logic [15:0] mem [16];
    logic [7:0] cnt_reg = 8'h00;
    initial rsp_o = '0;
    // idle data toggles so a stale word is never mistaken for an answer
    always @(posedge clk_i) begin
        rsp_o.done <= 1'b0;
        rsp_o.data <= ~rsp_o.data;
        cnt_reg <= req_i.valid && !rsp_o.done ? cnt_reg + 8'h01 : 8'h00;
        if (req_i.valid && !rsp_o.done && cnt_reg >= dly_i) begin
            rsp_o <= {1'b1, perr_i, berr_i, mem[req_i.addr[4:1]]};
            if (req_i.we)
                mem[req_i.addr[4:1]] <= req_i.data;
        end
    end
endmodule : hcs_host_model

// file: verification/hcs_core_test.sv
// bench for hcs_core: init error codes, command fetch, status posting
`timescale 1ns/1ns
module hcs_core_test;
    import hcs_pkg::*;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic dio_parity_err_i = 1'b0, hw_fault_i = 1'b0, perr = 1'b0, berr = 1'b0;
    logic ack_o, host_int_o, adapter_check_o;
    logic mem_fault_i = 1'b0;
    logic [7:0] adr_i = 8'h00, dly = 8'h02;
    logic [31:0] dat_i = 32'h0, dat_o, rd;
    hcs_dma_req_t dma_req_o;
    hcs_dma_rsp_t dma_rsp_i;
    int err_total = 0, checks_done = 0;
    // per row: offset, bad value, {dio, hw, parity, bus} faults with code
    logic [7:0] ea [16] = '{8'h04, 8'h08, 8'h08, 8'h08, 8'h0c, 8'h10, 8'h14,
        8'h18, 8'h1c, 8'h08, 8'h04, 8'h08, 8'h04, 8'h04, 8'h04, 8'h04};
    logic [15:0] ev [16] = '{16'h15, 16'h201, 16'h3, 16'h401, 16'h3, 16'h3,
        16'h0, 16'h1, 16'h9, 16'h7, 16'h16, 16'h7, 16'h16, 16'h16, 16'h16,
        16'h16};
    logic [7:0] efc [16] = '{8'h01, 8'h02, 8'h02, 8'h02, 8'h03, 8'h04, 8'h05,
        8'h06, 8'h07, 8'h88, 8'h09, 8'h2a, 8'h1b, 8'h0c, 8'h4d, 8'h00};
    logic [15:0] okv [7] = '{16'h16, 16'h1, 16'h2, 16'h2, 16'h101, 16'h0,
        16'h8};
    always #5 clk_i = ~clk_i;
    hcs_core #(.DMA_TIMEOUT_CYC(50)) i_hcs_core (.clk_i, .rst_i, .cyc_i,
        .stb_i, .we_i, .adr_i, .sel_i(4'hf), .dat_i, .dat_o, .ack_o,
        .dma_req_o, .dma_rsp_i, .dio_parity_err_i, .hw_fault_i,
        .mem_fault_i, .llc_present_i(1'b0), .bia_word_i(16'h0),
        .host_int_o, .adapter_check_o);
    hcs_host_model i_hcs_host_model (.clk_i, .req_i(dma_req_o),
        .rsp_o(dma_rsp_i), .dly_i(dly), .perr_i(perr), .berr_i(berr));
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        int n;
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        rd = dat_o;
        {cyc_i, stb_i} <= 2'b00;
        cmp(32'(ack_o), 32'h1);
    endtask : wb
    task automatic wait_int(input logic lvl);
        for (int n = 0; host_int_o !== lvl && n < 300; n++) @(posedge clk_i);
        cmp(32'(host_int_o), 32'(lvl));
    endtask : wait_int
    task automatic init_run(input int i);
        int n;
        logic [3:0] code;
        code = efc[i][3:0];
        rst_i <= 1'b1;
        {dio_parity_err_i, hw_fault_i, perr, berr} <= efc[i][7:4];
        dly <= efc[i][3:0] == 4'h9 ? 8'h3c : 8'h02;
        i_hcs_host_model.mem[0] = {15'h0, efc[i][3:0] == 4'hc};
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int k = 0; k < 7; k++)
            wb(1'b1, 8'h04 + 8'(4 * k), {16'h0, okv[k]});
        wb(1'b1, ea[i], {16'h0, ev[i]});
        wb(1'b1, 8'h00, 32'h181);
        n = 0;
        do begin
            wb(1'b0, 8'h00, 32'h0);
            n++;
        end while (rd[9] !== 1'b1 && rd[11:10] !== 2'b00 && n < 300);
        cmp(32'({rd[15:12], rd[9]}),
            32'({code, code != 4'h0}));
        $display("test init code %0d done", efc[i][3:0]);
    endtask : init_run
    task automatic post(input logic [15:0] t);
        for (int k = 0; k < 4; k++)
            wb(1'b1, 8'h28 + 8'(4 * k), {16'h0, k == 0 ? t : 16'ha0 + 16'(k)});
        wb(1'b1, 8'h20, 32'h3);
    endtask : post
    task automatic chk_ssb(input logic [15:0] t);
        for (int k = 0; k < 4; k++)
            cmp({16'h0, i_hcs_host_model.mem[4 + k]},
                {16'h0, k == 0 ? t : 16'ha0 + 16'(k)});
    endtask : chk_ssb
    task automatic end_sim;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_sim
    initial begin
        for (int i = 0; i < 16; i++) init_run(i);
        wb(1'b0, 8'hc0, 32'h0);
        cmp(32'(rd[15:0]), 32'hffff);
        i_hcs_host_model.mem[0] = 16'h0003;
        i_hcs_host_model.mem[1] = 16'h1234;
        wb(1'b1, 8'h00, 32'h191);
        wait_int(1'b1);
        cmp({16'h0, i_hcs_host_model.mem[0]}, 32'h0);
        wb(1'b0, 8'h3c, 32'h0);
        cmp(rd, 32'h1234);
        wb(1'b0, 8'h24, 32'h0);
        cmp(rd, 32'h10);
        wb(1'b0, 8'h9c, 32'h0);
        cmp(rd, 32'h200);
        wb(1'b1, 8'h00, 32'h0);
        wait_int(1'b0);
        $display("test command done");
        post(HCS_ST_CMD);
        wait_int(1'b1);
        chk_ssb(HCS_ST_CMD);
        wb(1'b1, 8'h00, 32'h0);
        post(HCS_ST_RING);
        repeat (40) @(posedge clk_i);
        chk_ssb(HCS_ST_CMD);
        wait_int(1'b0);
        wb(1'b1, 8'h00, 32'h5);
        wait_int(1'b1);
        chk_ssb(HCS_ST_RING);
        $display("test status done");
        mem_fault_i <= 1'b1;
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        cmp(32'(adapter_check_o), 32'h1);
        $display("test memory fault done");
        end_sim();
    end
    initial begin
        #500000;
        err_total++;
        end_sim();
    end
endmodule : hcs_core_test
